// >>> hdl/phr_pkg.sv
// constants, field layout and state types for the phy ident and advertisement registers
package phr_pkg;

	// management frame register addresses
	localparam logic [4:0]  REG_IDENT_HIGH      = 5'h02;
	localparam logic [4:0]  REG_IDENT_LOW       = 5'h03;
	localparam logic [4:0]  REG_AUTONEG_ADV     = 5'h04;

	// identifier bits 3..24 in one word: bit 21 holds identifier bit 3 (arbitrary value)
	localparam logic [21:0] ORG_ID_BITS         = 22'h0A5C3E;
	// vendor model number and revision (arbitrary values)
	localparam logic [5:0]  VENDOR_MODEL_NUMBER = 6'h15;
	localparam logic [3:0]  MODEL_REVISION      = 4'h1;

	// identifier field positions
	localparam int          ID_LOW_ORG_LSB      = 10;
	localparam int          ID_LOW_MODEL_LSB    = 4;
	localparam int          ID_LOW_REV_LSB      = 0;

	// advertisement field positions
	localparam int          ADV_NEXT_PAGE       = 15;
	localparam int          ADV_RSVD_IEEE       = 14;
	localparam int          ADV_REMOTE_FAULT    = 13;
	localparam int          ADV_RSVD_FUTURE     = 12;
	localparam int          ADV_ASYM_PAUSE      = 11;
	localparam int          ADV_PAUSE           = 10;
	localparam int          ADV_T4              = 9;
	localparam int          ADV_STRAP_LSB       = 5;
	localparam int          ADV_SEL_LSB         = 0;

	// advertisement reset value and writable bit mask
	localparam logic [15:0] ADV_RESET           = 16'h0001;
	localparam logic [15:0] ADV_WR_MASK         = 16'hADFF;
	localparam logic [15:0] ADV_STRAP_MASK      = 16'h01E0;

	// management frame timing, counted in management clock bits
	localparam logic [5:0]  PREAMBLE_BITS       = 6'h20;
	localparam logic [5:0]  OP_BITS             = 6'h02;
	localparam logic [5:0]  ADDR_BITS           = 6'h05;
	localparam logic [5:0]  TA_BITS             = 6'h02;
	localparam logic [5:0]  DATA_BITS           = 6'h10;

	// management opcodes
	localparam logic [1:0]  OP_WRITE            = 2'h1;
	localparam logic [1:0]  OP_READ             = 2'h2;

	// frame receiver states
	typedef enum logic [2:0] {
		ST_PREAMBLE,
		ST_START,
		ST_OPCODE,
		ST_PHY_ADDR,
		ST_REG_ADDR,
		ST_TURN,
		ST_READ_DATA,
		ST_WRITE_DATA
	} phr_state_t;

endpackage : phr_pkg

// >>> hdl/phr_mdc_edge.sv
// management clock edge finder and data sampler
`timescale 1ns/1ps
module phr_mdc_edge
	import phr_pkg::*;
(
	// clock and reset
	input  wire logic sys_clk_in,
	input  wire logic reset_n_in,
	input  wire logic ce_in,
	// management pins, synchronous to sys_clk_in
	input  wire logic mdc_in,
	input  wire logic mdio_in,
	// sampled bit and its strobe
	output logic      rise_out,
	output logic      bit_out
);

	typedef struct packed {
		logic mdc_prev;
		logic rise;
		logic bit_val;
	} phr_edge_st_t;

	phr_edge_st_t st_q;
	phr_edge_st_t st_d;

	// the bit is taken in the same cycle the rising edge is seen, so data and strobe align
	always_comb begin
		st_d          = st_q;
		st_d.mdc_prev = mdc_in;
		st_d.rise     = mdc_in & ~st_q.mdc_prev;
		st_d.bit_val  = mdio_in;
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			// previous clock taken as high so an idle-high clock gives no false edge
			st_q <= '{mdc_prev: 1'b1, rise: 1'b0, bit_val: 1'b1};
		end else if (ce_in) begin
			st_q <= st_d;
		end
	end

	assign rise_out = st_q.rise;
	assign bit_out  = st_q.bit_val;

endmodule : phr_mdc_edge

// >>> hdl/phr_adv_reg.sv
// auto-negotiation advertisement register storage with strap-loaded ability bits
`timescale 1ns/1ps
module phr_adv_reg
	import phr_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        ce_in,
	// strap levels for 100 full, 100, 10 full, 10
	input  wire logic [3:0]  ability_strap_in,
	// write port
	input  wire logic        wr_in,
	input  wire logic [15:0] wr_data_in,
	// stored value
	output logic [15:0]      adv_out
);

	typedef struct packed {
		logic        strap_taken;
		logic [15:0] adv;
	} phr_adv_st_t;

	phr_adv_st_t st_q;
	phr_adv_st_t st_d;

	// straps are caught by the first enabled clock after reset release, not by the reset
	always_comb begin
		st_d = st_q;
		if (!st_q.strap_taken) begin
			st_d.strap_taken = 1'b1;
			st_d.adv         = (ADV_RESET & ~ADV_STRAP_MASK)
			                 | {7'h00, ability_strap_in, 5'h00};
		end else if (wr_in) begin
			// read-only and reserved bits never take write data
			st_d.adv = wr_data_in & ADV_WR_MASK;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_q.strap_taken <= 1'b0;
			st_q.adv         <= ADV_RESET;
		end else if (ce_in) begin
			st_q <= st_d;
		end
	end

	assign adv_out = st_q.adv;

endmodule : phr_adv_reg

// >>> hdl/phr_mgmt_top.sv
// management frame slave serving the phy ident and advertisement registers
//
// What this block does
// - upper ident register returns identifier bits 3..18; top two identifier bits dropped.
// - lower ident bits 15..10 return identifier bits 19..24 in order.
// - lower ident bits 9..4 return the six-bit vendor model number, msb at 9.
// - lower ident bits 3..0 return the four-bit revision, msb at bit 3.
// - advertisement register at address 4 holds abilities sent during negotiation.
// - advertisement bit 15 is read/write next page request, reset 0.
// - advertisement bit 14 ignores writes and reads 0.
// - advertisement bit 13 is read/write remote fault flag, reset 0.
// - advertisement bit 12 reserved, reads 0; software writes only 0.
// - advertisement bit 11 is read/write asymmetric pause flag, reset 0.
// - advertisement bit 10 is read/write symmetric pause flag, reset 0.
// - pause resolution result is reported in the control register, not here.
// - advertisement bit 9 is fixed 0, no 100BASE-T4.
// - advertisement bits 8..5 are read/write abilities whose reset values come from straps.
// - advertisement bits 4..0 are read/write selector, reset 00001.
`timescale 1ns/1ps
module phr_mgmt_top
	import phr_pkg::*;
(
	// clock, reset and clock enable
	input  wire logic        sys_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        ce_in,
	// station address and ability straps
	input  wire logic [4:0]  phy_addr_strap_in,
	input  wire logic [3:0]  ability_strap_in,
	// management serial pins
	input  wire logic        mdc_in,
	input  wire logic        mdio_in,
	output logic             mdio_out,
	output logic             mdio_oe_n_out,
	// advertised abilities toward the negotiation engine
	output logic [15:0]      adv_abilities_out
);

	// frame receiver state, all in one record
	typedef struct packed {
		phr_state_t  state;
		logic [5:0]  cnt;
		logic [1:0]  opcode;
		logic [4:0]  phy_addr;
		logic [4:0]  reg_addr;
		logic [15:0] shift;
		logic        wr_strobe;
		logic [15:0] wr_data;
		logic        drv_bit;
		logic        drv_oe_n;
	} phr_mgmt_st_t;

	phr_mgmt_st_t st_q;
	phr_mgmt_st_t st_d;

	logic        bit_rise;
	logic        bit_val;
	logic [15:0] adv_word;

	// edge finder for the management clock
	phr_mdc_edge u_edge (
		.sys_clk_in (sys_clk_in),
		.reset_n_in (reset_n_in),
		.ce_in      (ce_in),
		.mdc_in     (mdc_in),
		.mdio_in    (mdio_in),
		.rise_out   (bit_rise),
		.bit_out    (bit_val)
	);

	// advertisement register storage
	phr_adv_reg u_adv (
		.sys_clk_in       (sys_clk_in),
		.reset_n_in       (reset_n_in),
		.ce_in            (ce_in),
		.ability_strap_in (ability_strap_in),
		.wr_in            (st_q.wr_strobe),
		.wr_data_in       (st_q.wr_data),
		.adv_out          (adv_word)
	);

	// upper identifier word: identifier bits 3..18
	function automatic logic [15:0] ident_high_word();
		ident_high_word = ORG_ID_BITS[21:6];
	endfunction : ident_high_word

	// lower identifier word: identifier bits 19..24, model and revision
	function automatic logic [15:0] ident_low_word();
		logic [15:0] w;
		w                                  = 16'h0000;
		w[ID_LOW_ORG_LSB +: 6]             = ORG_ID_BITS[5:0];
		w[ID_LOW_MODEL_LSB +: 6]           = VENDOR_MODEL_NUMBER;
		w[ID_LOW_REV_LSB +: 4]             = MODEL_REVISION;
		ident_low_word = w;
	endfunction : ident_low_word

	// read decode; unmapped addresses read as zero
	function automatic logic [15:0] read_word(
		input logic [4:0]  addr,
		input logic [15:0] adv
	);
		logic [15:0] w;
		w = 16'h0000;
		unique case (addr)
			REG_IDENT_HIGH:  w = ident_high_word();
			REG_IDENT_LOW:   w = ident_low_word();
			// read-only zero bits are forced here too, whatever the storage holds
			REG_AUTONEG_ADV: w = adv & ADV_WR_MASK;
			default:         w = 16'h0000;
		endcase
		read_word = w;
	endfunction : read_word

	// one-bit shift into a five-bit address field
	function automatic logic [4:0] shift_in5(
		input logic [4:0] cur,
		input logic       b
	);
		shift_in5 = {cur[3:0], b};
	endfunction : shift_in5

	// frame walker: every step happens on a sampled rising edge of the management clock
	always_comb begin
		st_d           = st_q;
		st_d.wr_strobe = 1'b0;
		if (bit_rise) begin
			unique case (st_q.state)
				// count ones; a zero after enough ones is the first start bit
				ST_PREAMBLE: begin
					if (bit_val) begin
						if (st_q.cnt != PREAMBLE_BITS) begin
							st_d.cnt = st_q.cnt + 6'h01;
						end
					end else if (st_q.cnt == PREAMBLE_BITS) begin
						st_d.state = ST_START;
						st_d.cnt   = 6'h00;
					end else begin
						st_d.cnt = 6'h00;
					end
				end
				// second start bit must be one, otherwise hunt for a fresh preamble
				ST_START: begin
					st_d.cnt = 6'h00;
					if (bit_val) begin
						st_d.state = ST_OPCODE;
					end else begin
						st_d.state = ST_PREAMBLE;
					end
				end
				// two opcode bits; illegal codes drop the frame
				ST_OPCODE: begin
					st_d.opcode = {st_q.opcode[0], bit_val};
					if (st_q.cnt == OP_BITS - 6'h01) begin
						st_d.cnt = 6'h00;
						if ({st_q.opcode[0], bit_val} == OP_READ ||
						    {st_q.opcode[0], bit_val} == OP_WRITE) begin
							st_d.state = ST_PHY_ADDR;
						end else begin
							st_d.state = ST_PREAMBLE;
						end
					end else begin
						st_d.cnt = st_q.cnt + 6'h01;
					end
				end
				// station address, msb first
				ST_PHY_ADDR: begin
					st_d.phy_addr = shift_in5(st_q.phy_addr, bit_val);
					if (st_q.cnt == ADDR_BITS - 6'h01) begin
						st_d.cnt   = 6'h00;
						st_d.state = ST_REG_ADDR;
					end else begin
						st_d.cnt = st_q.cnt + 6'h01;
					end
				end
				// register address, msb first; read data is latched at its last bit
				ST_REG_ADDR: begin
					st_d.reg_addr = shift_in5(st_q.reg_addr, bit_val);
					if (st_q.cnt == ADDR_BITS - 6'h01) begin
						st_d.cnt   = 6'h00;
						st_d.state = ST_TURN;
						st_d.shift = read_word(shift_in5(st_q.reg_addr, bit_val),
						                       adv_word);
					end else begin
						st_d.cnt = st_q.cnt + 6'h01;
					end
				end
				// turnaround: on a read to us, drive zero for the second bit
				ST_TURN: begin
					if (st_q.cnt == TA_BITS - 6'h01) begin
						st_d.cnt = 6'h00;
						if (st_q.opcode == OP_READ) begin
							st_d.state   = ST_READ_DATA;
							// a read for another station keeps the released level high
							st_d.drv_bit = st_q.drv_oe_n | st_q.shift[15];
							st_d.shift   = {st_q.shift[14:0], 1'b0};
						end else begin
							st_d.state = ST_WRITE_DATA;
						end
					end else begin
						st_d.cnt = st_q.cnt + 6'h01;
						if (st_q.opcode == OP_READ && st_q.phy_addr == phy_addr_strap_in) begin
							st_d.drv_bit  = 1'b0;
							st_d.drv_oe_n = 1'b0;
						end
					end
				end
				// shift sixteen read bits out, msb first, then release the pin
				ST_READ_DATA: begin
					if (st_q.cnt == DATA_BITS - 6'h01) begin
						st_d.cnt      = 6'h00;
						st_d.state    = ST_PREAMBLE;
						st_d.drv_bit  = 1'b1;
						st_d.drv_oe_n = 1'b1;
					end else begin
						st_d.cnt     = st_q.cnt + 6'h01;
						st_d.drv_bit = st_q.drv_oe_n | st_q.shift[15];
						st_d.shift   = {st_q.shift[14:0], 1'b0};
					end
				end
				// gather sixteen write bits; only the advertisement word takes them
				ST_WRITE_DATA: begin
					st_d.shift = {st_q.shift[14:0], bit_val};
					if (st_q.cnt == DATA_BITS - 6'h01) begin
						st_d.cnt   = 6'h00;
						st_d.state = ST_PREAMBLE;
						if (st_q.phy_addr == phy_addr_strap_in &&
						    st_q.reg_addr == REG_AUTONEG_ADV) begin
							st_d.wr_strobe = 1'b1;
							st_d.wr_data   = {st_q.shift[14:0], bit_val};
						end
						// ident addresses fall through here and are dropped
					end else begin
						st_d.cnt = st_q.cnt + 6'h01;
					end
				end
				default: begin
					st_d.state    = ST_PREAMBLE;
					st_d.cnt      = 6'h00;
					st_d.drv_bit  = 1'b1;
					st_d.drv_oe_n = 1'b1;
				end
			endcase
		end
	end

	// state register; clock enable low freezes everything
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_q.state     <= ST_PREAMBLE;
			st_q.cnt       <= 6'h00;
			st_q.opcode    <= 2'h0;
			st_q.phy_addr  <= 5'h00;
			st_q.reg_addr  <= 5'h00;
			st_q.shift     <= 16'h0000;
			st_q.wr_strobe <= 1'b0;
			st_q.wr_data   <= 16'h0000;
			st_q.drv_bit   <= 1'b1;
			st_q.drv_oe_n  <= 1'b1;
		end else if (ce_in) begin
			st_q <= st_d;
		end
	end

	// pin drive comes straight from the state flops
	assign mdio_out      = st_q.drv_bit;
	assign mdio_oe_n_out = st_q.drv_oe_n;

	// pause bits go out as stored; the resolved result lives in the control register
	assign adv_abilities_out = adv_word;

endmodule : phr_mgmt_top

// >>> dv/phr_mgmt_asserts.sv
// concurrent checks on the pins of the management register slave
`timescale 1ns/1ps
module phr_mgmt_asserts
	import phr_pkg::*;
(
	// clock, reset and enable
	input  wire logic        sys_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        ce_in,
	// straps
	input  wire logic [4:0]  phy_addr_strap_in,
	input  wire logic [3:0]  ability_strap_in,
	// management pins and advertised value
	input  wire logic        mdc_in,
	input  wire logic        mdio_in,
	input  wire logic        mdio_out,
	input  wire logic        mdio_oe_n_out,
	input  wire logic [15:0] adv_abilities_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);

	// bits that never store a written one
	property p_rsvd_ieee;
		adv_abilities_out[14] == 1'b0;
	endproperty
	a_rsvd_ieee: assert property (p_rsvd_ieee) else $error("adv bit 14 set");
	property p_rsvd_future;
		adv_abilities_out[12] == 1'b0;
	endproperty
	a_rsvd_future: assert property (p_rsvd_future) else $error("adv bit 12 set");
	property p_no_t4;
		adv_abilities_out[9] == 1'b0;
	endproperty
	a_no_t4: assert property (p_no_t4) else $error("adv bit 9 set");
	// reset value stands until the first enabled edge, then straps land in 8:5
	property p_reset_val;
		$rose(reset_n_in) |-> adv_abilities_out == 16'h0001;
	endproperty
	a_reset_val: assert property (p_reset_val) else $error("adv reset value");
	property p_strap_load;
		$rose(reset_n_in) && ce_in |=>
			adv_abilities_out == {7'h00, $past(ability_strap_in), 5'h01};
	endproperty
	a_strap_load: assert property (p_strap_load) else $error("strap capture");
	// an idle slave leaves a one on its data output
	property p_idle_high;
		mdio_oe_n_out |-> mdio_out;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("idle data not high");
	property p_ta_zero;
		$fell(mdio_oe_n_out) |-> mdio_out == 1'b0;
	endproperty
	a_ta_zero: assert property (p_ta_zero) else $error("turnaround not zero");
	// a low enable freezes register and pin state
	property p_freeze;
		!ce_in |=> $stable(adv_abilities_out) && $stable(mdio_oe_n_out);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");

	c_read: cover property ($fell(mdio_oe_n_out));
	c_write: cover property ($changed(adv_abilities_out) && mdio_oe_n_out);
	c_freeze: cover property (!ce_in);
endmodule : phr_mgmt_asserts

bind phr_mgmt_top phr_mgmt_asserts u_chk (
	.sys_clk_in,
	.reset_n_in,
	.ce_in,
	.phy_addr_strap_in,
	.ability_strap_in,
	.mdc_in,
	.mdio_in,
	.mdio_out,
	.mdio_oe_n_out,
	.adv_abilities_out
);

// >>> dv/phr_sta_model.sv
// station management model that clocks frames onto the serial pins
`timescale 1ns/1ps
module phr_sta_model
	import phr_pkg::*;
(
	// clock and resolved data wire
	input  wire logic sys_clk_in,
	input  wire logic mdio_in,
	// management pins toward the slave
	output logic      mdc_out,
	output logic      mdio_out
);
	// clock starts low and data starts released high; between frames both keep the levels of the last bit
	initial begin
		mdc_out = 1'b0;
		mdio_out = 1'b1;
	end

	// one bit: four cycles low, sample at the rise, four cycles high
	task automatic mbit(input logic b, output logic s);
		mdc_out <= 1'b0;
		mdio_out <= b;
		repeat (4) @(posedge sys_clk_in);
		s = mdio_in;
		mdc_out <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
	endtask : mbit

	// whole frame; on a read the wire is released from turnaround on
	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] bits;
		logic        s;
		bits = {32'hFFFFFFFF, 2'b01, op, pa, ra, (op == OP_WRITE) ? {2'b10, wd} : 18'h3FFFF};
		rd = 16'h0000;
		for (int i = 63; i >= 0; i--) begin
			mbit(bits[i], s);
			rd = {rd[14:0], s};
		end
	endtask : frame
endmodule : phr_sta_model

// >>> dv/phr_mgmt_top_tb.sv
// self-checking bench for the management register slave
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) begin \
			miscompares++; \
			$display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
		end \
	end

module phr_mgmt_top_tb
	import phr_pkg::*;
;
	localparam logic [4:0] PA = 5'h0B;
	logic        sys_clk    = 1'b0;
	logic        reset_n    = 1'b0;
	logic        ce         = 1'b1;
	logic [4:0]  addr_strap = PA;
	logic [3:0]  abil_strap = 4'hA;
	logic        mdc;
	logic        sta_mdio;
	logic        dut_mdio;
	logic        dut_oe_n;
	logic        mdio_w;
	logic [15:0] adv;
	logic [15:0] rd;
	logic [15:0] wtab [3] = '{16'hEFFF, 16'h0000, 16'h6C32};
	int          miscompares = 0;
	int          cmp_count = 0;

	always #20 sys_clk = ~sys_clk;
	// wire level: slave when enabled, else the station, which drives high when released
	assign mdio_w = dut_oe_n ? sta_mdio : dut_mdio;

	phr_mgmt_top u_dut (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .ce_in(ce),
		.phy_addr_strap_in(addr_strap), .ability_strap_in(abil_strap), .mdc_in(mdc),
		.mdio_in(mdio_w), .mdio_out(dut_mdio), .mdio_oe_n_out(dut_oe_n),
		.adv_abilities_out(adv));
	phr_sta_model u_sta (.sys_clk_in(sys_clk), .mdio_in(mdio_w), .mdc_out(mdc),
		.mdio_out(sta_mdio));

	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	// reset for eight cycles with a new strap setting
	task automatic do_reset(input logic [3:0] s);
		reset_n <= 1'b0;
		abil_strap <= s;
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
	endtask : do_reset

	task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
		logic [15:0] d;
		u_sta.frame(OP_READ, PA, ra, 16'h0000, d);
		`CHK(d, exp)
	endtask : rd_chk

	// extra cycles let the write strobe land before anyone looks
	task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
		logic [15:0] d;
		u_sta.frame(OP_WRITE, pa, ra, wd, d);
		repeat (4) @(posedge sys_clk);
	endtask : wr

	initial begin
		do_reset(4'hA);
		`CHK(adv, {7'h00, 4'hA, 5'h01})
		rd_chk(REG_AUTONEG_ADV, {7'h00, 4'hA, 5'h01});
		do_reset(4'h5);
		rd_chk(REG_AUTONEG_ADV, {7'h00, 4'h5, 5'h01});
		$display("test reset_values done");
		rd_chk(REG_IDENT_HIGH, ORG_ID_BITS[21:6]);
		wr(PA, REG_IDENT_HIGH, ~ORG_ID_BITS[21:6]);
		wr(PA, REG_IDENT_LOW, 16'h0000);
		rd_chk(REG_IDENT_HIGH, ORG_ID_BITS[21:6]);
		rd_chk(REG_IDENT_LOW, {ORG_ID_BITS[5:0], VENDOR_MODEL_NUMBER, MODEL_REVISION});
		$display("test identifiers done");
		// software only writes zero to bit 12; bits 14 and 9 must read zero
		for (int i = 0; i < 3; i++) begin
			wr(PA, REG_AUTONEG_ADV, wtab[i]);
			`CHK(adv, wtab[i] & 16'hBDFF)
			rd_chk(REG_AUTONEG_ADV, wtab[i] & 16'hBDFF);
		end
		$display("test advertisement done");
		wr(PA ^ 5'h01, REG_AUTONEG_ADV, 16'h0001);
		`CHK(adv, 16'h2C32)
		u_sta.frame(OP_READ, PA ^ 5'h01, REG_AUTONEG_ADV, 16'h0000, rd);
		`CHK(rd, 16'hFFFF)
		wr(PA, 5'h05, 16'h0001);
		`CHK(adv, 16'h2C32)
		rd_chk(5'h05, 16'h0000);
		ce <= 1'b0;
		repeat (6) @(posedge sys_clk);
		ce <= 1'b1;
		@(posedge sys_clk);
		`CHK(adv, 16'h2C32)
		$display("test refusals done");
		final_report();
	end

	// hang guard
	initial begin
		repeat (40000) @(posedge sys_clk);
		`CHK(1'b0, 1'b1)
		final_report();
	end
endmodule : phr_mgmt_top_tb
